// ### include/ierr_log_map.svh
// field positions, codes and reset values of the interconnect error status register
`ifndef IERR_LOG_MAP_SVH
`define IERR_LOG_MAP_SVH

// bank numbers answered on the read port
`define BANK_NUM_A 5'h05
`define BANK_NUM_B 5'h0c
`define BANK_NUM_C 5'h13

// field positions inside the 64-bit status word
`define ARCH_LSB 0
`define ARCH_MSB 15
`define CAUSE_LSB 16
`define CAUSE_MSB 21
`define DETAIL_LSB 22
`define DETAIL_MSB 31
`define CNT_LSB 38
`define CNT_MSB 52
`define VALID_BITS_LSB 57

// architectural compound codes
`define ARCH_UNSUPPORTED_PKT 16'h0c0f
`define ARCH_OTHER_ERR 16'h0e0f

// model-specific cause codes, uncorrectable group
`define CAUSE_UC_PHY_INIT 6'h00
`define CAUSE_UC_DRIFT_ALARM 6'h01
`define CAUSE_UC_LATENCY_ROLL 6'h02
`define CAUSE_UC_CRC_ABORT 6'h10
`define CAUSE_UC_UNSUP_PKT 6'h11
`define CAUSE_UC_CTRL_ERR 6'h12
`define CAUSE_UC_PARAM_EXCH 6'h13
`define CAUSE_UC_MESH_CTRL 6'h1f
// correctable group
`define CAUSE_COR_FLOOR 6'h20
`define CAUSE_COR_INIT_ABORT 6'h20
`define CAUSE_COR_PHY_RESET 6'h21
`define CAUSE_COR_LANE_X8 6'h22
`define CAUSE_COR_LPS_NO_RST 6'h23
`define CAUSE_COR_LPS_RST 6'h24
`define CAUSE_COR_PWS_EXIT 6'h25
`define CAUSE_COR_RETRY_OK 6'h30
`define CAUSE_COR_RETRY_REINIT 6'h31

// counter limits and reset values
`define CNT_MAX 15'h7fff
`define CNT_ONE 15'h0001
`define STATUS_RESET 64'h0000_0000_0000_0000

`endif

// ### include/ierr_log_pkg.sv
// types shared by the interconnect error status log
package ierr_log_pkg;

    // one error report from a link agent, same clock as the log
    typedef struct packed {
        logic valid;        // one-cycle report strobe
        logic [5:0] cause;  // model-specific cause code
        logic [9:0] detail; // control error detail vector
        logic en;           // error reporting enabled
        logic miscv;        // misc register holds data
        logic addrv;        // address register holds data
        logic pcc;          // processor context corrupt
    } error_event_t;

    // architectural validity indicators, msb first
    typedef struct packed {
        logic val;
        logic over;
        logic uc;
        logic en;
        logic miscv;
        logic addrv;
        logic pcc;
    } validity_t;

    // the stored content of one bank
    typedef struct packed {
        validity_t flags;
        logic [5:0] cause;
        logic [9:0] detail;
        logic [15:0] arch;
    } bank_fields_t;

endpackage : ierr_log_pkg

// ### hw/interconnect_error_status_log.sv
// interconnect error status log: three 64-bit status banks for the link agents

`timescale 1ns/1ps
`default_nettype none

`include "ierr_log_map.svh"

module interconnect_error_status_log
    import ierr_log_pkg::*;
#(
    parameter int NUM_BANKS = 3 // one bank per link agent
) (
    input wire logic ref_clk_in,                         // 250 MHz core clock
    input wire logic sys_rst_in,                         // synchronous, active high
    input wire error_event_t evt_in [NUM_BANKS],         // error reports, one per agent
    input wire logic [NUM_BANKS-1:0] clear_in,           // software write of zero, per bank
    input wire logic rd_en_in,                           // status read request
    input wire logic [4:0] rd_bank_in,                   // bank number to read
    output logic [63:0] rd_data_out,                     // read data, registered
    output logic rd_ack_out,                             // read answered, one cycle
    output logic rd_err_out,                             // bank number not mapped
    output logic [NUM_BANKS-1:0] bank_valid_out,         // bank holds a logged error
    output logic [NUM_BANKS-1:0] bank_uc_out             // bank holds an uncorrected error
);

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------

    // true only for cause codes the log may record
    function automatic logic cause_listed(input logic [5:0] c);
        logic ok;
        ok = 1'b0;
        case (c)
            `CAUSE_UC_PHY_INIT,
            `CAUSE_UC_DRIFT_ALARM,
            `CAUSE_UC_LATENCY_ROLL: ok = 1'b1;
            `CAUSE_UC_CRC_ABORT,
            `CAUSE_UC_UNSUP_PKT,
            `CAUSE_UC_CTRL_ERR: ok = 1'b1;
            `CAUSE_UC_PARAM_EXCH,
            `CAUSE_UC_MESH_CTRL: ok = 1'b1;
            `CAUSE_COR_INIT_ABORT,
            `CAUSE_COR_PHY_RESET,
            `CAUSE_COR_LANE_X8: ok = 1'b1;
            `CAUSE_COR_LPS_NO_RST,
            `CAUSE_COR_LPS_RST,
            `CAUSE_COR_PWS_EXIT: ok = 1'b1;
            `CAUSE_COR_RETRY_OK,
            `CAUSE_COR_RETRY_REINIT: ok = 1'b1;
            default: ok = 1'b0;                  // reserved codes
        endcase
        return ok;
    endfunction : cause_listed

    // uncorrectable causes sit below the correctable floor
    function automatic logic cause_uncorr(input logic [5:0] c);
        return (c < `CAUSE_COR_FLOOR);
    endfunction : cause_uncorr

    // compound code follows from the cause alone
    function automatic logic [15:0] arch_code(input logic [5:0] c);
        logic [15:0] code;
        if (c == `CAUSE_UC_UNSUP_PKT) begin
            code = `ARCH_UNSUPPORTED_PKT;
        end else begin
            code = `ARCH_OTHER_ERR;
        end
        return code;
    endfunction : arch_code

    // detail vector survives only alongside the control error cause
    function automatic logic [9:0] detail_gate(input logic [5:0] c, input logic [9:0] d);
        logic [9:0] g;
        if (c == `CAUSE_UC_CTRL_ERR) begin
            g = d;     // bits 22..31 as reported
        end else begin
            g = '0;
        end
        return g;
    endfunction : detail_gate

    // assemble the 64-bit word, unused fields forced to zero
    function automatic logic [63:0] pack_status(input bank_fields_t f, input logic [14:0] cnt);
        logic [63:0] w;
        w = `STATUS_RESET;                               // 37:32 and 56:53 stay zero
        w[`ARCH_MSB:`ARCH_LSB] = f.arch;
        w[`CAUSE_MSB:`CAUSE_LSB] = f.cause;
        w[`DETAIL_MSB:`DETAIL_LSB] = f.detail;
        w[`CNT_MSB:`CNT_LSB] = cnt;
        w[63:`VALID_BITS_LSB] = f.flags;
        return w;
    endfunction : pack_status

    // ------------------------------------------------------------------
    // bank storage
    // ------------------------------------------------------------------

    bank_fields_t bank_q [NUM_BANKS];       // logged fields per bank
    logic [14:0] cnt_q [NUM_BANKS];         // corrected error counts
    logic [NUM_BANKS-1:0] accept;           // report is legal and will be logged
    logic [NUM_BANKS-1:0] new_uc;           // report is uncorrectable

    // a report counts only when its cause is on the list
    always_comb begin
        for (int i = 0; i < NUM_BANKS; i++) begin
            accept[i] = evt_in[i].valid && cause_listed(evt_in[i].cause);
            new_uc[i] = cause_uncorr(evt_in[i].cause);
        end
    end

    // ------------------------------------------------------------------
    // error logging
    // ------------------------------------------------------------------

    // first error wins, but an uncorrected error displaces a corrected one;
    // a clear in the same cycle as a report clears first, so the report is kept
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < NUM_BANKS; i++) begin
                bank_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_BANKS; i++) begin
                bank_fields_t base;
                base = clear_in[i] ? bank_fields_t'('0) : bank_q[i];
                if (accept[i]) begin
                    if (!base.flags.val || (new_uc[i] && !base.flags.uc)) begin
                        // take the new report, older one is lost
                        bank_q[i].arch <= arch_code(evt_in[i].cause);
                        bank_q[i].cause <= evt_in[i].cause;
                        bank_q[i].detail <= detail_gate(evt_in[i].cause,
                                                        evt_in[i].detail);
                        bank_q[i].flags.val <= 1'b1;
                        bank_q[i].flags.over <= base.flags.val;
                        bank_q[i].flags.uc <= new_uc[i];
                        bank_q[i].flags.en <= evt_in[i].en;
                        bank_q[i].flags.miscv <= evt_in[i].miscv;
                        bank_q[i].flags.addrv <= evt_in[i].addrv;
                        bank_q[i].flags.pcc <= evt_in[i].pcc;
                    end else begin
                        // keep the stored error, mark the overflow
                        bank_q[i] <= base;
                        bank_q[i].flags.over <= 1'b1;
                    end
                end else begin
                    bank_q[i] <= base;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // corrected error count
    // ------------------------------------------------------------------

    // counts every accepted correctable report, even when not stored;
    // holds at the top so software can see the counter has run out
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < NUM_BANKS; i++) begin
                cnt_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_BANKS; i++) begin
                logic [14:0] base_cnt;
                base_cnt = clear_in[i] ? 15'h0000 : cnt_q[i];
                if (accept[i] && !new_uc[i] && (base_cnt != `CNT_MAX)) begin
                    cnt_q[i] <= base_cnt + `CNT_ONE;
                end else begin
                    cnt_q[i] <= base_cnt;              // saturated or idle
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------

    logic [1:0] rd_idx;     // decoded bank index
    logic rd_hit;           // bank number is one of ours

    // bank number decode
    always_comb begin
        rd_idx = 2'h0;
        rd_hit = 1'b0;
        if (rd_bank_in == `BANK_NUM_A) begin
            rd_idx = 2'h0;
            rd_hit = 1'b1;
        end else if (rd_bank_in == `BANK_NUM_B) begin
            rd_idx = 2'h1;
            rd_hit = 1'b1;
        end else if (rd_bank_in == `BANK_NUM_C) begin
            rd_idx = 2'h2;
            rd_hit = 1'b1;
        end
    end

    logic [63:0] rd_data_q;  // captured status word
    logic rd_ack_q;          // answer strobe
    logic rd_err_q;          // unmapped bank strobe

    // one-cycle answer; unmapped banks read zero and flag an error
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            rd_data_q <= `STATUS_RESET;
            rd_ack_q <= 1'b0;
            rd_err_q <= 1'b0;
        end else begin
            rd_ack_q <= rd_en_in;
            rd_err_q <= rd_en_in && !rd_hit;
            if (rd_en_in && rd_hit && (int'(rd_idx) < NUM_BANKS)) begin
                rd_data_q <= pack_status(bank_q[rd_idx], cnt_q[rd_idx]);
            end else if (rd_en_in) begin
                rd_data_q <= `STATUS_RESET;
            end
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------

    assign rd_data_out = rd_data_q;
    assign rd_ack_out = rd_ack_q;
    assign rd_err_out = rd_err_q;

    // summary flags straight from the stored validity bits
    always_comb begin
        for (int i = 0; i < NUM_BANKS; i++) begin
            bank_valid_out[i] = bank_q[i].flags.val;
            bank_uc_out[i] = bank_q[i].flags.uc;
        end
    end

endmodule : interconnect_error_status_log

`default_nettype wire

// ### tb/ierr_log_assertions.sv
// concurrent checks on the ports of the interconnect error status log
`timescale 1ns/1ps
`default_nettype none
`include "ierr_log_map.svh"
module ierr_log_assertions
    import ierr_log_pkg::*;
#(
    parameter int NUM_BANKS = 3
) (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire error_event_t evt_in [NUM_BANKS],
    input wire logic [NUM_BANKS-1:0] clear_in,
    input wire logic rd_en_in,
    input wire logic [4:0] rd_bank_in,
    input wire logic [63:0] rd_data_out,
    input wire logic rd_ack_out,
    input wire logic rd_err_out,
    input wire logic [NUM_BANKS-1:0] bank_valid_out,
    input wire logic [NUM_BANKS-1:0] bank_uc_out
);
    // ----------------------------------------
    // helpers and properties
    // ----------------------------------------
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    // only these causes may ever be stored
    function automatic logic listed(input logic [5:0] c);
        return c inside {6'h00, 6'h01, 6'h02, 6'h10, 6'h11, 6'h12, 6'h13, 6'h1f,
                         6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h30, 6'h31};
    endfunction : listed
    logic mapped; // read names one of the three banks
    assign mapped = rd_bank_in inside {`BANK_NUM_A, `BANK_NUM_B, `BANK_NUM_C};
    logic shown; // a read returned a logged word
    assign shown = rd_ack_out && rd_data_out[63];
    a_read_answer: assert property (rd_en_in |=> rd_ack_out)
        else $error("read not answered");
    a_ack_cause: assert property (rd_ack_out |-> $past(rd_en_in))
        else $error("answer without read");
    a_unmapped_bank: assert property (rd_en_in && !mapped |=> rd_err_out && rd_data_out == 64'h0)
        else $error("unmapped bank not refused");
    a_mapped_bank: assert property (rd_en_in && mapped |=> !rd_err_out)
        else $error("mapped bank refused");
    a_arch_code: assert property (shown |-> rd_data_out[15:0] ==
        ((rd_data_out[21:16] == 6'h11) ? 16'h0c0f : 16'h0e0f))
        else $error("bad compound code");
    a_cause_listed: assert property (shown |-> listed(rd_data_out[21:16]))
        else $error("reserved cause stored");
    a_detail_gated: assert property (rd_ack_out && rd_data_out[21:16] != 6'h12
        |-> rd_data_out[31:22] == 10'h0)
        else $error("detail set for other cause");
    a_reserved_zero: assert property (rd_ack_out |-> rd_data_out[37:32] == 6'h0
        && rd_data_out[56:53] == 4'h0)
        else $error("reserved bits set");
    a_uc_group: assert property (shown && !rd_data_out[62]
        |-> rd_data_out[61] == (rd_data_out[21:16] < 6'h20))
        else $error("uc flag disagrees with cause");
    a_event_logged: assert property (evt_in[0].valid && listed(evt_in[0].cause)
        |=> bank_valid_out[0])
        else $error("event not logged");
    a_uc_logged: assert property (evt_in[0].valid && evt_in[0].cause < 6'h20
        && listed(evt_in[0].cause) |=> bank_uc_out[0])
        else $error("uc event not flagged");
    a_unlisted_ignored: assert property (evt_in[0].valid && !listed(evt_in[0].cause)
        && !bank_valid_out[0] |=> !bank_valid_out[0])
        else $error("reserved cause logged");
endmodule : ierr_log_assertions
`default_nettype wire

// ### tb/interconnect_error_status_log_test.sv
// self-checking bench for the interconnect error status log
`timescale 1ns/1ps
`default_nettype none
`include "ierr_log_map.svh"
`define CHECK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module interconnect_error_status_log_test
    import ierr_log_pkg::*;
;
    // ----------------------------------------
    // stimulus, expectations, checks
    // ----------------------------------------
    typedef struct packed { logic [5:0] cause; logic listed; } row_t; // cause beside legality
    logic ref_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    error_event_t evt_in [3];
    logic [2:0] clear_in = 3'h0;
    logic rd_en_in = 1'b0;
    logic [4:0] rd_bank_in = 5'h00;
    logic [63:0] rd_data_out;
    logic rd_ack_out;
    logic rd_err_out;
    logic [2:0] bank_valid_out;
    logic [2:0] bank_uc_out;
    int err_count = 0;
    int samples_checked = 0;
    // every listed cause, then reserved ones that must leave no trace
    row_t rows [20] = '{'{6'h00, 1'b1}, '{6'h01, 1'b1}, '{6'h02, 1'b1}, '{6'h10, 1'b1},
        '{6'h11, 1'b1}, '{6'h12, 1'b1}, '{6'h13, 1'b1}, '{6'h1f, 1'b1}, '{6'h20, 1'b1},
        '{6'h21, 1'b1}, '{6'h22, 1'b1}, '{6'h23, 1'b1}, '{6'h24, 1'b1}, '{6'h25, 1'b1},
        '{6'h30, 1'b1}, '{6'h31, 1'b1}, '{6'h03, 1'b0}, '{6'h14, 1'b0}, '{6'h26, 1'b0},
        '{6'h3f, 1'b0}};
    always #2 ref_clk_in = ~ref_clk_in;
    interconnect_error_status_log #(.NUM_BANKS(3)) DUT (.ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in), .evt_in(evt_in), .clear_in(clear_in), .rd_en_in(rd_en_in),
        .rd_bank_in(rd_bank_in), .rd_data_out(rd_data_out), .rd_ack_out(rd_ack_out),
        .rd_err_out(rd_err_out), .bank_valid_out(bank_valid_out), .bank_uc_out(bank_uc_out));
    // expected word; en is always reported set, the other copies clear
    function automatic logic [63:0] exp_word(input logic [5:0] c, input logic [9:0] d,
                                             input logic [14:0] n, input logic ov);
        return {1'b1, ov, c < 6'h20, 4'b1000, 4'h0, n, 6'h0, (c == 6'h12) ? d : 10'h0, c,
                (c == 6'h11) ? 16'h0c0f : 16'h0e0f};
    endfunction : exp_word
    // one-cycle report with every detail bit raised and en set, other flags clear;
    // the strobe drops at the next negedge, followed by one idle cycle
    task automatic send(input int b, input logic [5:0] c);
        evt_in[b] = '{valid: 1'b1, cause: c, detail: 10'h3ff, en: 1'b1, default: 1'b0};
        @(negedge ref_clk_in);
        evt_in[b].valid = 1'b0;
        @(negedge ref_clk_in); // idle gap so back-to-back calls never redrive in one step
    endtask : send
    // answer lands one cycle after the request
    task automatic read(input logic [4:0] bank, output logic [63:0] w, output logic e);
        rd_en_in = 1'b1;
        rd_bank_in = bank;
        @(negedge ref_clk_in);
        rd_en_in = 1'b0;
        `CHECK(rd_ack_out, 1'b1) // answer timing
        w = rd_data_out;
        e = rd_err_out;
        @(negedge ref_clk_in); // idle gap before the next request
    endtask : read
    task automatic wrap_up();
        $display("checked %0d, wrong %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up
    // a full run stops well short of this
    initial begin
        #200000;
        err_count++;
        wrap_up();
    end
    initial begin
        logic [63:0] w;
        logic e;
        evt_in = '{default: '0};
        repeat (20) @(negedge ref_clk_in);
        sys_rst_in = 1'b0;
        read(`BANK_NUM_A, w, e);
        `CHECK(w, 64'h0) // empty after reset
        for (int i = 0; i < 20; i++) begin
            clear_in[0] = 1'b1;
            @(negedge ref_clk_in);
            clear_in[0] = 1'b0;
            send(0, rows[i].cause);
            read(`BANK_NUM_A, w, e);
            `CHECK(w, rows[i].listed ? exp_word(rows[i].cause, 10'h3ff, (rows[i].cause >= 6'h20)
                ? 15'h0001 : 15'h0000, 1'b0) : 64'h0) // whole word
            `CHECK(bank_uc_out[0], rows[i].listed && rows[i].cause < 6'h20)
        end
        $display("table of causes done");
        send(1, 6'h22);
        send(1, 6'h12);
        read(`BANK_NUM_B, w, e);
        `CHECK(w, exp_word(6'h12, 10'h3ff, 15'h0001, 1'b1)) // uc replaces
        send(1, 6'h30);
        read(`BANK_NUM_B, w, e);
        `CHECK(w, exp_word(6'h12, 10'h3ff, 15'h0002, 1'b1)) // first kept
        read(5'h06, w, e);
        `CHECK({e, w}, {1'b1, 64'h0}) // unmapped bank
        $display("overwrite and refusal done");
        evt_in[2] = '{valid: 1'b1, cause: 6'h21, en: 1'b1, default: 1'b0};
        repeat (32770) @(negedge ref_clk_in);
        evt_in[2].valid = 1'b0;
        read(`BANK_NUM_C, w, e);
        `CHECK(w, exp_word(6'h21, 10'h0, 15'h7fff, 1'b1)) // count saturates
        sys_rst_in = 1'b1;
        repeat (2) @(negedge ref_clk_in);
        sys_rst_in = 1'b0;
        read(`BANK_NUM_C, w, e);
        `CHECK({bank_valid_out, w}, 67'h0) // mid-run reset
        $display("saturation and reset done");
        wrap_up();
    end
endmodule : interconnect_error_status_log_test
bind interconnect_error_status_log ierr_log_assertions #(.NUM_BANKS(NUM_BANKS)) u_chk (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .evt_in(evt_in), .clear_in(clear_in),
    .rd_en_in(rd_en_in), .rd_bank_in(rd_bank_in), .rd_data_out(rd_data_out),
    .rd_ack_out(rd_ack_out), .rd_err_out(rd_err_out), .bank_valid_out(bank_valid_out),
    .bank_uc_out(bank_uc_out));
`default_nettype wire
